// *** src/ppo_profile_position_options.sv ***
/*
 * ppo_profile_position_options: object dictionary slave for the profile
 * position option word, following error, slippage threshold and
 * correction speed, plus controlword/statusword handshake handling,
 * relative target base selection, rotary direction policy and slippage
 * monitoring.
 * Assumes a motion core on the same clock that supplies positions,
 * speeds and setpoint events, and a fieldbus stack that issues one
 * single-cycle read or write at a time and waits for odAck_q.
 */
`timescale 1ns/100ps

module ppo_profile_position_options #(
    parameter int TIMER_W = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // object dictionary access
    input wire logic odWrite,
    input wire logic odRead,
    input wire logic [15:0] odIndex,
    input wire logic [31:0] odWdata,
    output logic [31:0] odRdata_q,
    output logic odAck_q,
    output logic odErr_q,
    // motion core status
    input wire logic ppMode,
    input wire logic velMode,
    input wire logic setpointTaken,
    input wire logic targetReached,
    input wire logic canAccept,
    input wire logic signed [31:0] targetPos,
    input wire logic signed [31:0] rampPos,
    input wire logic signed [31:0] actualPos,
    input wire logic signed [31:0] rangeMin,
    input wire logic signed [31:0] rangeMax,
    input wire logic signed [31:0] followErr,
    input wire logic signed [31:0] corrSpeed,
    // slippage inputs
    input wire logic signed [31:0] actualSpeed,
    input wire logic signed [31:0] setSpeed,
    input wire logic [TIMER_W-1:0] slipTimeLimit,
    input wire logic slipReaction,
    // results to motion core
    output logic signed [31:0] absTarget_q,
    output logic targetValid_q,
    output logic dirPositive_q,
    output logic viaLimit_q,
    output logic slipErrLog_q,
    output logic [15:0] controlWord_q,
    output logic [15:0] statusWord_q
);
    // reserved 11 falls back to the default 00
    function automatic logic [1:0] optSel(input logic [15:0] w, input int lsb);
        logic [1:0] f;
        f = w[lsb +: 2];
        optSel = (f == ppo_pkg::OPT_11) ? ppo_pkg::OPT_00 : f;
    endfunction

    logic [15:0] posOpt_q;
    logic signed [31:0] slipThr_q;
    logic signed [31:0] followErr_q;
    logic signed [31:0] corrSpeed_q;
    logic signed [31:0] prevTarget_q;
    logic hasPrev_q;
    logic [TIMER_W-1:0] slipCnt_q;
    logic slipFlag_q;
    logic [1:0] relSel;
    logic [1:0] clrSel;
    logic [1:0] dirSel;
    logic signed [32:0] base;
    logic signed [32:0] raw;
    logic signed [32:0] span;
    logic signed [32:0] tgt;
    logic signed [32:0] diff;
    logic fwdDir;
    logic goPos;
    logic goVia;
    logic autoClr;
    logic cwWrite;
    logic signed [32:0] speedDev;
    logic [32:0] devAbs;
    logic [32:0] thrAbs;
    logic slipEnable;
    logic slipExceed;

    assign relSel = optSel(posOpt_q, ppo_pkg::RELATIVE_BASE_LSB);
    assign clrSel = optSel(posOpt_q, ppo_pkg::SETPOINT_AUTOCLEAR_LSB);
    assign dirSel = posOpt_q[ppo_pkg::ROTARY_DIRECTION_LSB +: 2]; // 11 is shortest path, not reserved
    assign cwWrite = odWrite && odIndex == ppo_pkg::IDX_CONTROL_WORD;

    // target base selection and wrap at the range limits
    always_comb begin
        base = 33'sh0;
        if (controlWord_q[ppo_pkg::CW_RELATIVE]) begin
            case (relSel)
                ppo_pkg::OPT_01: base = 33'(rampPos);
                ppo_pkg::OPT_10: base = 33'(actualPos);
                default: base = hasPrev_q ? 33'(prevTarget_q) : 33'sh0;
            endcase
        end
        raw = base + 33'(targetPos);
        span = 33'(rangeMax) - 33'(rangeMin);
        tgt = raw;
        // passing a limit wraps the demand round by one span
        if (span > 33'sh0 && raw > 33'(rangeMax)) begin
            tgt = raw - span;
        end else if (span > 33'sh0 && raw < 33'(rangeMin)) begin
            tgt = raw + span;
        end
        diff = tgt - 33'(actualPos);
        if (diff < 33'sh0) begin
            diff = diff + span;
        end
        fwdDir = tgt >= 33'(actualPos);
        case (dirSel)
            ppo_pkg::OPT_01: begin
                goPos = 1'b0;
                goVia = tgt > 33'(actualPos);
            end
            ppo_pkg::OPT_10: begin
                goPos = 1'b1;
                goVia = tgt < 33'(actualPos);
            end
            ppo_pkg::OPT_11: begin
                goPos = diff < (span >>> 1);
                goVia = goPos != fwdDir;
            end
            default: begin
                goPos = fwdDir;
                goVia = 1'b0;
            end
        endcase
    end

    // new target latched when the core takes a setpoint
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            absTarget_q <= ppo_pkg::ZERO_WORD;
            prevTarget_q <= ppo_pkg::ZERO_WORD;
            hasPrev_q <= 1'b0;
            targetValid_q <= 1'b0;
            dirPositive_q <= 1'b0;
            viaLimit_q <= 1'b0;
        end else begin
            targetValid_q <= 1'b0;
            if (setpointTaken && ppMode) begin
                absTarget_q <= tgt[31:0];
                prevTarget_q <= tgt[31:0];
                hasPrev_q <= 1'b1;
                targetValid_q <= 1'b1;
                dirPositive_q <= goPos;
                viaLimit_q <= goVia;
            end
        end
    end

    // device-side release of the new setpoint bit
    always_comb begin
        case (clrSel)
            ppo_pkg::OPT_01: autoClr = statusWord_q[ppo_pkg::SW_SETPOINT_ACK] && targetReached;
            ppo_pkg::OPT_10: autoClr = statusWord_q[ppo_pkg::SW_SETPOINT_ACK] && canAccept;
            default: autoClr = 1'b0;
        endcase
    end

    // controlword: a host write in the same cycle beats the release
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            controlWord_q <= ppo_pkg::CONTROL_WORD_RESET;
        end else if (cwWrite) begin
            controlWord_q <= odWdata[15:0];
        end else if (autoClr) begin
            controlWord_q[ppo_pkg::CW_NEW_SETPOINT] <= 1'b0;
        end
    end

    // acknowledge drops once the request bit is low, whoever cleared it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            statusWord_q <= 16'h0000;
        end else begin
            if (setpointTaken && ppMode) begin
                statusWord_q[ppo_pkg::SW_SETPOINT_ACK] <= 1'b1;
            end else if (!controlWord_q[ppo_pkg::CW_NEW_SETPOINT]) begin
                statusWord_q[ppo_pkg::SW_SETPOINT_ACK] <= 1'b0;
            end
            statusWord_q[ppo_pkg::SW_SLIPPAGE] <= slipFlag_q;
        end
    end

    // slippage deviation against the symmetric threshold
    always_comb begin
        speedDev = 33'(actualSpeed) - 33'(setSpeed);
        devAbs = speedDev[32] ? 33'(-speedDev) : 33'(speedDev);
        thrAbs = slipThr_q[31] ? 33'(-33'(slipThr_q)) : 33'(33'(slipThr_q));
        slipEnable = velMode && slipThr_q != ppo_pkg::SLIP_DISABLE;
        slipExceed = slipEnable && devAbs > thrAbs;
    end

    // persistence timer, saturating, cleared on recovery
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slipCnt_q <= '0;
            slipFlag_q <= 1'b0;
        end else if (!slipExceed) begin
            slipCnt_q <= '0;
            slipFlag_q <= 1'b0;
        end else begin
            if (slipCnt_q != '1) begin
                slipCnt_q <= slipCnt_q + 1'b1;
            end
            if (slipCnt_q > slipTimeLimit) begin
                slipFlag_q <= 1'b1;
            end
        end
    end

    // one log pulse per fault onset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slipErrLog_q <= 1'b0;
        end else begin
            slipErrLog_q <= slipReaction && slipExceed && !slipFlag_q && slipCnt_q > slipTimeLimit;
        end
    end

    // read-only monitors sampled every cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            followErr_q <= ppo_pkg::ZERO_WORD;
            corrSpeed_q <= ppo_pkg::ZERO_WORD;
        end else begin
            followErr_q <= followErr;
            corrSpeed_q <= corrSpeed;
        end
    end

    // writable option and threshold objects
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            posOpt_q <= ppo_pkg::POS_OPTION_RESET;
            slipThr_q <= ppo_pkg::SLIP_THRESH_RESET;
        end else if (odWrite) begin
            if (odIndex == ppo_pkg::IDX_POS_OPTION) begin
                posOpt_q <= odWdata[15:0] & ppo_pkg::POS_OPTION_MASK;
            end
            if (odIndex == ppo_pkg::IDX_SLIP_THRESH) begin
                slipThr_q <= odWdata;
            end
        end
    end

    // answer path: one cycle after the request, error on bad access
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            odAck_q <= 1'b0;
            odErr_q <= 1'b0;
            odRdata_q <= ppo_pkg::ZERO_WORD;
        end else begin
            odAck_q <= odRead || odWrite;
            odErr_q <= 1'b0;
            odRdata_q <= ppo_pkg::ZERO_WORD;
            if (odRead) begin
                case (odIndex)
                    ppo_pkg::IDX_CONTROL_WORD: odRdata_q <= {16'h0000, controlWord_q};
                    ppo_pkg::IDX_STATUS_WORD: odRdata_q <= {16'h0000, statusWord_q};
                    ppo_pkg::IDX_POS_OPTION: odRdata_q <= {16'h0000, posOpt_q};
                    ppo_pkg::IDX_FOLLOW_ERR: odRdata_q <= followErr_q;
                    ppo_pkg::IDX_SLIP_THRESH: odRdata_q <= slipThr_q;
                    ppo_pkg::IDX_CORR_SPEED: odRdata_q <= corrSpeed_q;
                    default: odErr_q <= 1'b1;
                endcase
            end else if (odWrite) begin
                // status and monitor objects refuse writes
                case (odIndex)
                    ppo_pkg::IDX_CONTROL_WORD: odErr_q <= 1'b0;
                    ppo_pkg::IDX_POS_OPTION: odErr_q <= 1'b0;
                    ppo_pkg::IDX_SLIP_THRESH: odErr_q <= 1'b0;
                    default: odErr_q <= 1'b1;
                endcase
            end
        end
    end

    // checks on the guarded behaviour
    optMask_a: assert property (@(posedge clk) disable iff (!rst_b)
        (posOpt_q & ~ppo_pkg::POS_OPTION_MASK) == 16'h0000)
        else $error("unsupported option bits set");
    optWrite_a: assert property (@(posedge clk) disable iff (!rst_b)
        odWrite && odIndex == ppo_pkg::IDX_POS_OPTION |=> posOpt_q == ($past(odWdata[15:0]) & 16'h00F3))
        else $error("option word write not stored");
    absBase_a: assert property (@(posedge clk) disable iff (!rst_b)
        setpointTaken && ppMode && !controlWord_q[ppo_pkg::CW_RELATIVE] |=> absTarget_q == $past(tgt[31:0])
        && $past(base) == 33'sh0)
        else $error("absolute move used a base");
    actualBase_a: assert property (@(posedge clk) disable iff (!rst_b)
        setpointTaken && ppMode && controlWord_q[ppo_pkg::CW_RELATIVE] && posOpt_q[1:0] == 2'h2
        |-> base == 33'(actualPos))
        else $error("relative base not actual position");
    rampBase_a: assert property (@(posedge clk) disable iff (!rst_b)
        controlWord_q[ppo_pkg::CW_RELATIVE] && posOpt_q[1:0] == 2'h1 |-> base == 33'(rampPos))
        else $error("relative base not ramp output");
    negOnly_a: assert property (@(posedge clk) disable iff (!rst_b)
        setpointTaken && ppMode && posOpt_q[7:6] == 2'h1 |=> !dirPositive_q && targetValid_q)
        else $error("negative-only axis moved positive");
    posOnly_a: assert property (@(posedge clk) disable iff (!rst_b)
        setpointTaken && ppMode && posOpt_q[7:6] == 2'h2 |=> dirPositive_q && targetValid_q)
        else $error("positive-only axis moved negative");
    autoClear_a: assert property (@(posedge clk) disable iff (!rst_b)
        posOpt_q[5:4] == 2'h2 && statusWord_q[ppo_pkg::SW_SETPOINT_ACK] && canAccept && !cwWrite
        |=> !controlWord_q[ppo_pkg::CW_NEW_SETPOINT] ##1 !statusWord_q[ppo_pkg::SW_SETPOINT_ACK]
        || $past(setpointTaken))
        else $error("new setpoint not released");
    noAutoClear_a: assert property (@(posedge clk) disable iff (!rst_b)
        (posOpt_q[5:4] == 2'h0 || posOpt_q[5:4] == 2'h3) && !cwWrite
        |=> controlWord_q == $past(controlWord_q))
        else $error("controlword changed without host");
    slipOff_a: assert property (@(posedge clk) disable iff (!rst_b)
        slipThr_q == ppo_pkg::SLIP_DISABLE |=> !slipFlag_q)
        else $error("slippage flagged while disabled");
    slipRestart_a: assert property (@(posedge clk) disable iff (!rst_b)
        !slipExceed |=> slipCnt_q == '0 ##1 !slipFlag_q || $past(slipExceed))
        else $error("slippage timer not restarted");
    slipStatus_a: assert property (@(posedge clk) disable iff (!rst_b)
        slipFlag_q |=> statusWord_q[ppo_pkg::SW_SLIPPAGE])
        else $error("slippage flag not in statusword");
    monitors_a: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 followErr_q == $past(followErr) && corrSpeed_q == $past(corrSpeed))
        else $error("monitor value not tracked");

    // main scenarios
    relMove_c: cover property (@(posedge clk) disable iff (!rst_b)
        setpointTaken && ppMode && controlWord_q[ppo_pkg::CW_RELATIVE]);
    reachClear_c: cover property (@(posedge clk) disable iff (!rst_b)
        posOpt_q[5:4] == 2'h1 && autoClr);
    shortPath_c: cover property (@(posedge clk) disable iff (!rst_b)
        targetValid_q && viaLimit_q && posOpt_q[7:6] == 2'h3);
    slipFault_c: cover property (@(posedge clk) disable iff (!rst_b) slipErrLog_q);
endmodule

// *** src/ppo_pkg.sv ***
/*
 * ppo_pkg: constants for the profile position option block: object
 * dictionary indices, option word fields, control and status bit
 * positions, reset values and the slippage disable value.
 * Assumes nothing of its surroundings; it is imported by scoped name only.
 */
package ppo_pkg;
    // object dictionary indices
    localparam logic [15:0] IDX_CONTROL_WORD = 16'h6040;
    localparam logic [15:0] IDX_STATUS_WORD = 16'h6041;
    localparam logic [15:0] IDX_POS_OPTION = 16'h60F2;
    localparam logic [15:0] IDX_FOLLOW_ERR = 16'h60F4;
    localparam logic [15:0] IDX_SLIP_THRESH = 16'h60F8;
    localparam logic [15:0] IDX_CORR_SPEED = 16'h60FA;

    // option word fields (low bit of each two-bit field)
    localparam int RELATIVE_BASE_LSB = 0;
    localparam int SETPOINT_AUTOCLEAR_LSB = 4;
    localparam int ROTARY_DIRECTION_LSB = 6;
    localparam logic [15:0] POS_OPTION_MASK = 16'h00F3;
    localparam logic [15:0] POS_OPTION_RESET = 16'h0001;

    // two-bit option encodings
    localparam logic [1:0] OPT_00 = 2'h0;
    localparam logic [1:0] OPT_01 = 2'h1;
    localparam logic [1:0] OPT_10 = 2'h2;
    localparam logic [1:0] OPT_11 = 2'h3;

    // control and status word bits
    localparam int CW_NEW_SETPOINT = 4;
    localparam int CW_RELATIVE = 6;
    localparam int SW_SETPOINT_ACK = 12;
    localparam int SW_SLIPPAGE = 13;
    localparam logic [15:0] CONTROL_WORD_RESET = 16'h0000;

    // slippage monitor
    localparam logic [31:0] SLIP_THRESH_RESET = 32'h0000_0190;
    localparam logic [31:0] SLIP_DISABLE = 32'h7FFF_FFFF;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// *** test/ppo_core_model.sv ***
/*
 * ppo_core_model: behavioural motion core facing the option block.
 * Pulses setpoint acceptance on request and reports target reached only
 * after a travel time, so reach-based release can be observed late.
 * Assumes the bench calls pulse() from a falling clock edge.
 */
`timescale 1ns/100ps
module ppo_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // motion status towards the block
    output logic setpointTaken,
    output logic targetReached
);
    int reachDelay = 0;
    int left = 0;

    initial begin
        setpointTaken = 1'b0;
        targetReached = 1'b1;
    end

    // travel time: reached drops at each accepted setpoint, rises reachDelay+1 cycles later
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            targetReached <= 1'b1;
            left <= 0;
        end else if (setpointTaken) begin
            targetReached <= 1'b0;
            left <= reachDelay;
        end else if (left > 0) begin
            left <= left - 1;
        end else begin
            targetReached <= 1'b1;
        end
    end

    // one-cycle acceptance pulse, returns in the cycle after it was taken
    task automatic pulse();
        @(negedge clk);
        setpointTaken = 1'b1;
        @(negedge clk);
        setpointTaken = 1'b0;
    endtask
endmodule

// *** test/ppo_profile_position_options_tb.sv ***
/*
 * ppo_profile_position_options_tb: self-checking bench for the option
 * block: object access, relative base, direction policy, setpoint
 * release and slippage monitoring.
 * Assumes the design package and ppo_core_model are compiled first.
 */
`timescale 1ns/100ps
module ppo_profile_position_options_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic odWrite = 1'b0, odRead = 1'b0, odAck_q, odErr_q;
    logic [15:0] odIndex = 16'h0000;
    logic [31:0] odWdata = 32'h0000_0000, odRdata_q;
    logic ppMode = 1'b1, velMode = 1'b0, setpointTaken, targetReached, canAccept = 1'b1, slipReaction = 1'b1;
    logic signed [31:0] targetPos = 32'h0, rampPos = 32'h3E8, actualPos = 32'h7D0;
    logic signed [31:0] rangeMin = 32'hF000_0000, rangeMax = 32'h1000_0000;
    logic signed [31:0] followErr = 32'h0, corrSpeed = 32'h0, actualSpeed = 32'h3E8, setSpeed = 32'h3E8;
    logic [31:0] slipTimeLimit = 32'h3;
    logic signed [31:0] absTarget_q;
    logic targetValid_q, dirPositive_q, viaLimit_q, slipErrLog_q;
    logic [15:0] controlWord_q, statusWord_q;
    logic [1:0] acOpt [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
    int n_mismatch = 0;
    int n_compared = 0;
    int slipPulses = 0;

    // 250 MHz clock
    always #2 clk = ~clk;

    ppo_profile_position_options #(.TIMER_W(32)) DUT (
        .clk(clk), .rst_b(rst_b), .odWrite(odWrite), .odRead(odRead), .odIndex(odIndex),
        .odWdata(odWdata), .odRdata_q(odRdata_q), .odAck_q(odAck_q), .odErr_q(odErr_q),
        .ppMode(ppMode), .velMode(velMode), .setpointTaken(setpointTaken), .targetReached(targetReached),
        .canAccept(canAccept), .targetPos(targetPos), .rampPos(rampPos), .actualPos(actualPos),
        .rangeMin(rangeMin), .rangeMax(rangeMax), .followErr(followErr), .corrSpeed(corrSpeed),
        .actualSpeed(actualSpeed), .setSpeed(setSpeed), .slipTimeLimit(slipTimeLimit),
        .slipReaction(slipReaction), .absTarget_q(absTarget_q), .targetValid_q(targetValid_q),
        .dirPositive_q(dirPositive_q), .viaLimit_q(viaLimit_q), .slipErrLog_q(slipErrLog_q),
        .controlWord_q(controlWord_q), .statusWord_q(statusWord_q)
    );

    ppo_core_model core (.clk(clk), .rst_b(rst_b), .setpointTaken(setpointTaken), .targetReached(targetReached));

    // count log pulses; a stuck level would count many times
    always @(posedge clk) begin
        if (slipErrLog_q === 1'b1) slipPulses++;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one object access: request for one cycle, answer checked the cycle after
    task automatic acc(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       input logic [31:0] expRd, input logic expErr);
        @(negedge clk);
        odWrite = wr;
        odRead = !wr;
        odIndex = idx;
        odWdata = wd;
        @(negedge clk);
        odWrite = 1'b0;
        odRead = 1'b0;
        chk("odAck", 32'h1, {31'h0, odAck_q});
        chk("odErr", {31'h0, expErr}, {31'h0, odErr_q});
        if (!wr) chk("odRdata", expRd, odRdata_q);
    endtask

    // configure, hand a setpoint over and check the latched move
    task automatic sp(input logic [15:0] cw, input logic [15:0] opt, input logic [31:0] tgt,
                      input logic [31:0] expAbs, input logic expDir, input logic expVia);
        acc(1'b1, ppo_pkg::IDX_POS_OPTION, {16'h0, opt}, 32'h0, 1'b0);
        acc(1'b1, ppo_pkg::IDX_CONTROL_WORD, {16'h0, cw}, 32'h0, 1'b0);
        targetPos = tgt;
        core.pulse();
        chk("targetValid", 32'h1, {31'h0, targetValid_q});
        chk("absTarget", expAbs, absTarget_q);
        chk("dirPositive", {31'h0, expDir}, {31'h0, dirPositive_q});
        chk("viaLimit", {31'h0, expVia}, {31'h0, viaLimit_q});
    endtask

    task automatic waitChk(input int n, input logic exp);
        repeat (n) @(negedge clk);
        chk("slipFlag", {31'h0, exp}, {31'h0, statusWord_q[ppo_pkg::SW_SLIPPAGE]});
    endtask

    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // cut a hang short well past the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        results();
    end

    initial begin
        logic ac2, acDone;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        acc(1'b0, ppo_pkg::IDX_POS_OPTION, 32'h0, 32'h1, 1'b0);
        acc(1'b0, ppo_pkg::IDX_SLIP_THRESH, 32'h0, 32'h190, 1'b0);
        acc(1'b0, ppo_pkg::IDX_FOLLOW_ERR, 32'h0, 32'h0, 1'b0);
        acc(1'b1, ppo_pkg::IDX_POS_OPTION, 32'hFFFF, 32'h0, 1'b0);
        acc(1'b0, ppo_pkg::IDX_POS_OPTION, 32'h0, 32'hF3, 1'b0);
        followErr = 32'h8000_0005;
        corrSpeed = 32'hFFFF_FF9C;
        acc(1'b0, ppo_pkg::IDX_FOLLOW_ERR, 32'h0, 32'h8000_0005, 1'b0);
        acc(1'b0, ppo_pkg::IDX_CORR_SPEED, 32'h0, 32'hFFFF_FF9C, 1'b0);
        acc(1'b1, ppo_pkg::IDX_CORR_SPEED, 32'h5, 32'h0, 1'b1);
        acc(1'b1, ppo_pkg::IDX_FOLLOW_ERR, 32'h5, 32'h0, 1'b1);
        acc(1'b0, 16'h60F3, 32'h0, 32'h0, 1'b1);
        $display("test access done");

        // relative base selection, no wrap with the wide range
        sp(16'h0040, 16'h0000, 32'h64, 32'h64, 1'b0, 1'b0);
        sp(16'h0000, 16'h0002, 32'h32, 32'h32, 1'b0, 1'b0);
        sp(16'h0040, 16'h0000, 32'h64, 32'h96, 1'b0, 1'b0);
        sp(16'h0040, 16'h0001, 32'h64, 32'h44C, 1'b0, 1'b0);
        sp(16'h0040, 16'h0002, 32'h64, 32'h834, 1'b1, 1'b0);
        sp(16'h0040, 16'h0003, 32'h64, 32'h898, 1'b1, 1'b0);
        ppMode = 1'b0;
        core.pulse();
        chk("targetValid", 32'h0, {31'h0, targetValid_q});
        ppMode = 1'b1;
        $display("test relative done");

        // direction policy on a 0..3600 axis, actual at 2000
        rangeMin = 32'h0;
        rangeMax = 32'hE10;
        sp(16'h0000, 16'h0000, 32'h3E8, 32'h3E8, 1'b0, 1'b0);
        sp(16'h0000, 16'h0000, 32'hFA0, 32'h190, 1'b0, 1'b0);
        sp(16'h0000, 16'h0040, 32'hBB8, 32'hBB8, 1'b0, 1'b1);
        sp(16'h0000, 16'h0080, 32'h3E8, 32'h3E8, 1'b1, 1'b1);
        sp(16'h0000, 16'h00C0, 32'hBB8, 32'hBB8, 1'b1, 1'b0);
        sp(16'h0000, 16'h00C0, 32'h64, 32'h64, 1'b1, 1'b1);
        sp(16'h0000, 16'h00C0, 32'h1F4, 32'h1F4, 1'b0, 1'b0);
        $display("test direction done");

        // setpoint release for every release option, travel takes 7 cycles
        core.reachDelay = 6;
        for (int i = 0; i < 4; i++) begin
            ac2 = (acOpt[i] == 2'h2);
            acDone = (acOpt[i] == 2'h2) || (acOpt[i] == 2'h1);
            acc(1'b1, ppo_pkg::IDX_POS_OPTION, {26'h0, acOpt[i], 4'h0}, 32'h0, 1'b0);
            acc(1'b1, ppo_pkg::IDX_CONTROL_WORD, 32'h10, 32'h0, 1'b0);
            core.pulse();
            chk("setpointAck", 32'h1, {31'h0, statusWord_q[12]});
            repeat (2) @(negedge clk);
            chk("newSetpoint", {31'h0, !ac2}, {31'h0, controlWord_q[4]});
            chk("setpointAck", {31'h0, !ac2}, {31'h0, statusWord_q[12]});
            repeat (8) @(negedge clk);
            chk("newSetpoint", {31'h0, !acDone}, {31'h0, controlWord_q[4]});
            chk("setpointAck", {31'h0, !acDone}, {31'h0, statusWord_q[12]});
            acc(1'b1, ppo_pkg::IDX_CONTROL_WORD, 32'h0, 32'h0, 1'b0);
            @(negedge clk);
            chk("setpointAck", 32'h0, {31'h0, statusWord_q[12]});
        end
        // release option 10 waits while the core cannot take a new setpoint
        canAccept = 1'b0;
        acc(1'b1, ppo_pkg::IDX_POS_OPTION, 32'h20, 32'h0, 1'b0);
        acc(1'b1, ppo_pkg::IDX_CONTROL_WORD, 32'h10, 32'h0, 1'b0);
        core.pulse();
        repeat (3) @(negedge clk);
        chk("newSetpoint", 32'h1, {31'h0, controlWord_q[4]});
        canAccept = 1'b1;
        repeat (2) @(negedge clk);
        chk("newSetpoint", 32'h0, {31'h0, controlWord_q[4]});
        chk("setpointAck", 32'h0, {31'h0, statusWord_q[12]});
        $display("test release done");

        // slippage: deviation exactly at the limit, then one above
        velMode = 1'b1;
        actualSpeed = 32'h578;
        waitChk(10, 1'b0);
        actualSpeed = 32'h579;
        waitChk(3, 1'b0);
        waitChk(4, 1'b1);
        chk("slipLog", 32'h1, slipPulses);
        actualSpeed = 32'h3E8;
        waitChk(3, 1'b0);
        actualSpeed = 32'h579;
        repeat (4) @(negedge clk);
        actualSpeed = 32'h3E8;
        @(negedge clk);
        actualSpeed = 32'h579;
        waitChk(4, 1'b0);
        actualSpeed = 32'h3E8;
        acc(1'b1, ppo_pkg::IDX_SLIP_THRESH, 32'h10, 32'h0, 1'b0);
        acc(1'b0, ppo_pkg::IDX_SLIP_THRESH, 32'h0, 32'h10, 1'b0);
        // no reaction configured: the fault is flagged but not logged
        slipReaction = 1'b0;
        actualSpeed = 32'h3F9;
        waitChk(8, 1'b1);
        chk("slipLog", 32'h1, slipPulses);
        // the 7FFF_FFFF threshold switches the monitor off even for a huge deviation
        setSpeed = 32'hFFFF_FC18;
        actualSpeed = 32'h7FFF_FFFF;
        acc(1'b1, ppo_pkg::IDX_SLIP_THRESH, 32'h7FFF_FFFF, 32'h0, 1'b0);
        waitChk(8, 1'b0);
        $display("test slippage done");
        results();
    end
endmodule
